// ---- rtl/double_integer_arith_unit.sv ----
// Function
// - Accumulator pair is signed 32-bit, A high
// - Memory operand: first word high, next low
// - Overflow cleared at start, set on overflow; compare leaves it
// - Extend flag is never cleared
// - Add: sum, overflow, extend on carry
// - Subtract: difference, overflow, extend on borrow
// - Reverse subtract: operand minus pair
// - Memory decrement, write back, skip zero
// - Memory increment, write back, skip zero
// - Negate; most negative stays itself with overflow; zero sets extend
// - Compare returns P+2, P+3, P+4
// - Increment wraps with overflow, extend
// - Decrement wraps with overflow, extend
// - Divide saturates on overflow or zero divisor
// - Reverse divide saturates likewise
// - Multiply saturates on 32-bit overflow
module double_integer_arith_unit (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 start,
  input  wire dbl_int_pkg::dbl_req_s req,
  output logic                      busy,
  output logic                      done,
  output dbl_int_pkg::dbl_rsp_s     rsp
);

  // ==========================================================
  // Helpers
  // Magnitude for the divider; the most negative value maps to 2^31
  function automatic logic [31:0] abs32(input logic [31:0] v);
    abs32 = v[31] ? (~v + 32'h1) : v;
  endfunction : abs32

  function automatic logic [31:0] neg32(input logic [31:0] v);
    neg32 = ~v + 32'h1;
  endfunction : neg32

  // ==========================================================
  // Operand assembly
  // A and the first memory word carry the upper halves
  logic [31:0] pair;
  logic [31:0] memory_operand;
  assign pair = {req.acc_a, req.acc_b};
  assign memory_operand = {req.memory_operand_hi, req.memory_operand_lo};

  // ==========================================================
  // Single-cycle arithmetic
  logic [32:0] add_w;
  logic [32:0] sub_w;
  logic [32:0] rsub_w;
  logic [31:0] neg_w;
  logic [31:0] inc_w;
  logic [31:0] dec_w;
  logic [31:0] minc_w;
  logic [31:0] mdec_w;
  logic        add_ovf;
  logic        sub_ovf;
  logic        rsub_ovf;
  logic        cmp_lt;
  logic [63:0] prod_w;
  logic [63:0] pair_sx;
  logic [63:0] memory_operand_sx;
  logic        mul_ovf;

  assign add_w    = {1'b0, pair} + {1'b0, memory_operand};
  assign sub_w    = {1'b0, pair} - {1'b0, memory_operand};
  assign rsub_w   = {1'b0, memory_operand} - {1'b0, pair};
  // Add overflows when both inputs share a sign that the result lacks; subtracts when the signs differ and the result lacks the minuend's sign
  assign add_ovf  = (pair[31] == memory_operand[31]) && (add_w[31] != pair[31]);
  assign sub_ovf  = (pair[31] != memory_operand[31]) && (sub_w[31] != pair[31]);
  assign rsub_ovf = (pair[31] != memory_operand[31]) && (rsub_w[31] != memory_operand[31]);
  assign neg_w    = neg32(pair);
  assign inc_w    = pair + dbl_int_pkg::ONE32;
  assign dec_w    = pair - dbl_int_pkg::ONE32;
  assign minc_w   = memory_operand + dbl_int_pkg::ONE32;
  assign mdec_w   = memory_operand - dbl_int_pkg::ONE32;
  // Signed order decides less and greater
  assign cmp_lt   = $signed(pair) < $signed(memory_operand);
  // Operands are sign-extended first so that no product bit is lost
  assign pair_sx  = {{32{pair[31]}}, pair};
  assign memory_operand_sx  = {{32{memory_operand[31]}}, memory_operand};
  assign prod_w   = pair_sx * memory_operand_sx;
  // Product fits only if the top 33 bits agree in sign
  assign mul_ovf  = !((&prod_w[63:31]) || !(|prod_w[63:31]));

  // ==========================================================
  // Divider setup: dividend and divisor by operation
  logic [31:0] dvd_s;
  logic [31:0] dvs_s;
  logic        q_neg;
  logic        div_zero;
  logic        div_min_ovf;
  logic        is_div;
  logic        is_rdiv;
  logic        div_early;
  assign is_rdiv     = (req.op == dbl_int_pkg::OP_RDIV);
  assign is_div      = (req.op == dbl_int_pkg::OP_DIV) || is_rdiv;
  assign dvd_s       = is_rdiv ? memory_operand : pair;
  assign dvs_s       = is_rdiv ? pair : memory_operand;
  assign q_neg       = dvd_s[31] ^ dvs_s[31];
  assign div_zero    = (dvs_s == dbl_int_pkg::ZERO32);
  // Only most negative over minus one leaves the 32-bit range
  assign div_min_ovf = (dvd_s == dbl_int_pkg::MOST_NEG) && (dvs_s == ~dbl_int_pkg::ZERO32);
  // Early saturation skips the step loop entirely
  assign div_early   = div_zero || div_min_ovf;

  // ==========================================================
  // Combinational answer for one-cycle operations
  dbl_int_pkg::dbl_rsp_s fast_rsp;
  logic [31:0]           res_w;
  logic                  ovf_w;
  logic                  ext_set;
  logic                  mem_we_w;
  logic [2:0]            ofs_w;
  logic                  ovf_keep;

  always_comb begin
    res_w    = pair;
    // Overflow starts cleared and is set only by the operation
    ovf_w    = 1'b0;
    ext_set  = 1'b0;
    mem_we_w = 1'b0;
    ofs_w    = dbl_int_pkg::NEXT_OFS;
    ovf_keep = 1'b0;
    unique case (req.op)
      dbl_int_pkg::OP_ADD: begin
        res_w   = add_w[31:0];
        ovf_w   = add_ovf;
        ext_set = add_w[32];
      end
      dbl_int_pkg::OP_SUB: begin
        res_w   = sub_w[31:0];
        ovf_w   = sub_ovf;
        ext_set = sub_w[32];
      end
      dbl_int_pkg::OP_RSUB: begin
        res_w   = rsub_w[31:0];
        ovf_w   = rsub_ovf;
        ext_set = rsub_w[32];
      end
      dbl_int_pkg::OP_NEG: begin
        res_w   = neg_w;
        ovf_w   = (pair == dbl_int_pkg::MOST_NEG);
        ext_set = (pair == dbl_int_pkg::ZERO32);
      end
      dbl_int_pkg::OP_INC: begin
        res_w   = inc_w;
        ovf_w   = (pair == dbl_int_pkg::SAT_VALUE);
        ext_set = (inc_w == dbl_int_pkg::ZERO32);
      end
      dbl_int_pkg::OP_DEC: begin
        res_w   = dec_w;
        ovf_w   = (pair == dbl_int_pkg::MOST_NEG);
        ext_set = (pair == dbl_int_pkg::ZERO32);
      end
      dbl_int_pkg::OP_MINC: begin
        res_w    = minc_w;
        mem_we_w = 1'b1;
        ofs_w    = (minc_w == dbl_int_pkg::ZERO32) ? dbl_int_pkg::SKIP_OFS : dbl_int_pkg::NEXT_OFS;
      end
      dbl_int_pkg::OP_MDEC: begin
        res_w    = mdec_w;
        mem_we_w = 1'b1;
        ofs_w    = (mdec_w == dbl_int_pkg::ZERO32) ? dbl_int_pkg::SKIP_OFS : dbl_int_pkg::NEXT_OFS;
      end
      dbl_int_pkg::OP_CMP: begin
        // Compare answers through the resume offset only
        ovf_keep = 1'b1;
        if (pair == memory_operand) begin
          ofs_w = dbl_int_pkg::CMP_EQ_OFS;
        end else if (cmp_lt) begin
          ofs_w = dbl_int_pkg::CMP_LT_OFS;
        end else begin
          ofs_w = dbl_int_pkg::CMP_GT_OFS;
        end
      end
      dbl_int_pkg::OP_MUL: begin
        res_w = mul_ovf ? dbl_int_pkg::SAT_VALUE : prod_w[31:0];
        ovf_w = mul_ovf;
      end
      default: begin
        // Unused codes return the pair with overflow cleared
        res_w = pair;
      end
    endcase
  end

  always_comb begin
    fast_rsp        = '0;
    // Memory-writing operations leave the pair untouched
    fast_rsp.acc_a  = mem_we_w ? req.acc_a : res_w[31:16];
    fast_rsp.acc_b  = mem_we_w ? req.acc_b : res_w[15:0];
    fast_rsp.mem_hi = mem_we_w ? res_w[31:16] : req.memory_operand_hi;
    fast_rsp.mem_lo = mem_we_w ? res_w[15:0] : req.memory_operand_lo;
    fast_rsp.mem_we = mem_we_w;
    fast_rsp.ovf    = ovf_w;
    fast_rsp.ovf_we = !ovf_keep;
    // Extend is only ever ORed in, never cleared
    fast_rsp.ext    = req.ext | ext_set;
    fast_rsp.pc_ofs = ofs_w;
  end

  // ==========================================================
  // Divider: restoring, one quotient bit per cycle
  // Gray codes along idle, step, finish
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_FIN  = 2'b11
  } div_state_e;

  div_state_e  st_q;
  div_state_e  st_d;
  logic [31:0] rem_q;
  logic [31:0] quo_q;
  logic [31:0] dvs_q;
  logic [5:0]  cnt_q;
  logic        qneg_q;
  logic        ext_hold_q;
  logic [15:0] mhi_q;
  logic [15:0] mlo_q;
  logic [32:0] trial_w;
  logic [31:0] shrem_w;
  logic        quo_ovf;
  logic [31:0] quo_signed;
  logic        div_go;
  logic        fast_go;
  logic        step_last;
  logic        st_step;
  logic        st_fin;

  // A start during a divide is dropped without notice
  assign div_go     = start && !busy && is_div;
  assign fast_go    = start && !busy && !is_div;
  assign st_step    = (st_q == ST_DIV);
  assign st_fin     = (st_q == ST_FIN);
  assign step_last  = (cnt_q == dbl_int_pkg::DIV_STEPS - 6'h1);
  // Dividend bits enter the remainder from the top of quo_q
  assign shrem_w    = {rem_q[30:0], quo_q[31]};
  assign trial_w    = {1'b0, shrem_w} - {1'b0, dvs_q};
  // A positive quotient of 2^31 cannot be represented
  assign quo_ovf    = !qneg_q && quo_q[31];
  // Truncation toward zero: the sign is put back after the loop
  assign quo_signed = qneg_q ? neg32(quo_q) : quo_q;

  // ==========================================================
  // Divider sequencing
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (div_go && div_early) begin
          st_d = ST_FIN;
        end else if (div_go) begin
          st_d = ST_DIV;
        end
      end
      ST_DIV: begin
        if (step_last) begin
          st_d = ST_FIN;
        end
      end
      ST_FIN:  st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  logic sat_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q       <= ST_IDLE;
      rem_q      <= '0;
      quo_q      <= '0;
      dvs_q      <= '0;
      cnt_q      <= '0;
      qneg_q     <= 1'b0;
      sat_q      <= 1'b0;
      ext_hold_q <= 1'b0;
      mhi_q      <= '0;
      mlo_q      <= '0;
    end else begin
      st_q <= st_d;
      // Operands are latched so req may change while busy
      if (div_go) begin
        rem_q      <= '0;
        quo_q      <= abs32(dvd_s);
        dvs_q      <= abs32(dvs_s);
        cnt_q      <= '0;
        qneg_q     <= q_neg;
        sat_q      <= div_early;
        ext_hold_q <= req.ext;
        mhi_q      <= req.memory_operand_hi;
        mlo_q      <= req.memory_operand_lo;
      end else if (st_step) begin
        // The remainder stays below the divisor, so its top bit is never lost
        cnt_q <= cnt_q + 6'h1;
        rem_q <= trial_w[32] ? shrem_w : trial_w[31:0];
        quo_q <= {quo_q[30:0], !trial_w[32]};
      end
    end
  end

  // ==========================================================
  // Answer registers
  logic                  div_sat;
  dbl_int_pkg::dbl_rsp_s div_rsp;
  assign div_sat = sat_q || quo_ovf;

  always_comb begin
    div_rsp        = '0;
    div_rsp.acc_a  = div_sat ? dbl_int_pkg::SAT_VALUE[31:16] : quo_signed[31:16];
    div_rsp.acc_b  = div_sat ? dbl_int_pkg::SAT_VALUE[15:0] : quo_signed[15:0];
    // Memory words go back unchanged; no write is asked
    div_rsp.mem_hi = mhi_q;
    div_rsp.mem_lo = mlo_q;
    div_rsp.ovf    = div_sat;
    div_rsp.ovf_we = 1'b1;
    div_rsp.ext    = ext_hold_q;
    div_rsp.pc_ofs = dbl_int_pkg::NEXT_OFS;
  end

  // ==========================================================
  // Output flip-flops
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      done <= 1'b0;
      busy <= 1'b0;
      rsp  <= '0;
    end else begin
      // busy falls on the edge that raises done, so a new start lines up
      done <= fast_go || st_fin;
      busy <= (st_d != ST_IDLE);
      if (fast_go) begin
        rsp <= fast_rsp;
      end else if (st_fin) begin
        rsp <= div_rsp;
      end
    end
  end

endmodule : double_integer_arith_unit

// ---- rtl/dbl_int_pkg.sv ----
package dbl_int_pkg;

  // ==========================================================
  // Operation codes
  typedef enum logic [3:0] {
    OP_ADD    = 4'h0,
    OP_SUB    = 4'h1,
    OP_RSUB   = 4'h2,
    OP_NEG    = 4'h3,
    OP_INC    = 4'h4,
    OP_DEC    = 4'h5,
    OP_MINC   = 4'h6,
    OP_MDEC   = 4'h7,
    OP_CMP    = 4'h8,
    OP_MUL    = 4'h9,
    OP_DIV    = 4'hA,
    OP_RDIV   = 4'hB
  } dbl_op_e;

  // ==========================================================
  // Constants
  localparam logic [31:0] SAT_VALUE     = 32'h7FFF_FFFF;
  localparam logic [31:0] MOST_NEG      = 32'h8000_0000;
  localparam logic [31:0] ONE32         = 32'h0000_0001;
  localparam logic [31:0] ZERO32        = 32'h0000_0000;
  localparam logic [2:0]  CMP_EQ_OFS    = 3'h2;
  localparam logic [2:0]  CMP_LT_OFS    = 3'h3;
  localparam logic [2:0]  CMP_GT_OFS    = 3'h4;
  localparam logic [2:0]  NEXT_OFS      = 3'h1;
  localparam logic [2:0]  SKIP_OFS      = 3'h2;
  localparam logic [5:0]  DIV_STEPS     = 6'h20;

  // ==========================================================
  // Request and answer carriers
  typedef struct packed {
    dbl_op_e     op;
    logic [15:0] acc_a;
    logic [15:0] acc_b;
    logic [15:0] memory_operand_hi;
    logic [15:0] memory_operand_lo;
    logic        ext;
  } dbl_req_s;

  typedef struct packed {
    logic [15:0] acc_a;
    logic [15:0] acc_b;
    logic [15:0] mem_hi;
    logic [15:0] mem_lo;
    logic        mem_we;
    logic        ovf;
    logic        ovf_we;
    logic        ext;
    logic [2:0]  pc_ofs;
  } dbl_rsp_s;

endpackage : dbl_int_pkg

// ---- sim/dbl_arith_checker.sv ----
module dbl_arith_checker (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire logic                  start,
  input wire dbl_int_pkg::dbl_req_s req,
  input wire logic                  busy,
  input wire logic                  done,
  input wire dbl_int_pkg::dbl_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Decoded request and answer
  wire logic [3:0]           op   = req.op;
  wire logic                 go   = start && !busy;
  wire logic [31:0]          pair = {req.acc_a, req.acc_b};
  wire logic [31:0]          memory_operand = {req.memory_operand_hi, req.memory_operand_lo};
  wire logic [31:0]          res  = {rsp.acc_a, rsp.acc_b};
  wire logic [31:0]          mem  = {rsp.mem_hi, rsp.mem_lo};
  wire logic                 dv   = op == dbl_int_pkg::OP_DIV || op == dbl_int_pkg::OP_RDIV;
  wire logic                 dv0  = (op == dbl_int_pkg::OP_DIV && memory_operand == 32'h0) ||
                                    (op == dbl_int_pkg::OP_RDIV && pair == 32'h0);

  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_add; go && op == dbl_int_pkg::OP_ADD |=> res == $past(pair) + $past(memory_operand); endproperty
  a_add: assert property (p_add) else $error("sum wrong");
  property p_ext; go && !dv && req.ext |=> rsp.ext; endproperty
  a_ext: assert property (p_ext) else $error("extend cleared");
  property p_mdec; go && op == dbl_int_pkg::OP_MDEC |=> rsp.mem_we && mem == $past(memory_operand) - 32'h1; endproperty
  a_mdec: assert property (p_mdec) else $error("memory decrement wrong");
  property p_skip; go && op == dbl_int_pkg::OP_MINC |=> (rsp.pc_ofs == 3'h2) == (mem == 32'h0); endproperty
  a_skip: assert property (p_skip) else $error("skip wrong");
  property p_neg; go && op == dbl_int_pkg::OP_NEG && pair == 32'h80000000 |=> res == 32'h80000000 && rsp.ovf; endproperty
  a_neg: assert property (p_neg) else $error("negate edge wrong");
  property p_cmp; go && op == dbl_int_pkg::OP_CMP |=> !rsp.ovf_we && res == $past(pair) && rsp.pc_ofs != 3'h1; endproperty
  a_cmp: assert property (p_cmp) else $error("compare altered state");
  property p_inc; go && op == dbl_int_pkg::OP_INC && pair == 32'h7FFFFFFF |=> res == 32'h80000000 && rsp.ovf; endproperty
  a_inc: assert property (p_inc) else $error("increment wrap wrong");
  property p_dec; go && op == dbl_int_pkg::OP_DEC && pair == 32'h0 |=> res == 32'hFFFFFFFF && rsp.ext; endproperty
  a_dec: assert property (p_dec) else $error("decrement wrap wrong");
  property p_div0; go && dv0 |-> ##[1:3] (done && res == 32'h7FFFFFFF && rsp.ovf); endproperty
  a_div0: assert property (p_div0) else $error("zero divisor not saturated");
  property p_busy; go && dv |=> busy; endproperty
  a_busy: assert property (p_busy) else $error("divide not busy");
  property p_mul; go && op == dbl_int_pkg::OP_MUL && pair == 32'h10000 && memory_operand == 32'h10000 |=> res == 32'h7FFFFFFF; endproperty
  a_mul: assert property (p_mul) else $error("product not saturated");
endmodule : dbl_arith_checker

bind double_integer_arith_unit dbl_arith_checker chk_u (.core_clk(core_clk), .rst_n(rst_n), .start(start),
  .req(req), .busy(busy), .done(done), .rsp(rsp));

// ---- sim/seq_model.sv ----
// Sequencer side: overflow flag, resume address and the two-word operand
module seq_model (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  done,
  input  wire dbl_int_pkg::dbl_rsp_s rsp,
  input  wire logic                  ld,
  input  wire logic [31:0]           ld_val,
  output logic                       ovf_q,
  output logic [31:0]                mem_q,
  output logic [15:0]                pc_q
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ovf_q <= 1'h0;
      mem_q <= 32'h0;
      pc_q  <= 16'h0;
    end else if (ld) begin
      mem_q <= ld_val;
    end else if (done) begin
      if (rsp.ovf_we) ovf_q <= rsp.ovf;
      if (rsp.mem_we) mem_q <= {rsp.mem_hi, rsp.mem_lo};
      pc_q <= pc_q + 16'(rsp.pc_ofs);
    end
  end
endmodule : seq_model

// ---- sim/double_integer_arith_unit_bench.sv ----
module double_integer_arith_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  core_clk, rst_n, start, busy, done, ld, ovf_q;
  logic [31:0]           mem_q, ld_val;
  logic [15:0]           pc_q;
  dbl_int_pkg::dbl_req_s req;
  dbl_int_pkg::dbl_rsp_s rsp;
  int                    error_cnt, n_compared;
  double_integer_arith_unit dut_u (.core_clk(core_clk), .rst_n(rst_n), .start(start), .req(req), .busy(busy),
    .done(done), .rsp(rsp));
  seq_model seq_u (.core_clk(core_clk), .rst_n(rst_n), .done(done), .rsp(rsp), .ld(ld), .ld_val(ld_val),
    .ovf_q(ovf_q), .mem_q(mem_q), .pc_q(pc_q));
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ==========================================================
  // Shared tasks
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Flags f: ovf, ext, mem write, resume offset
  task automatic run(input dbl_int_pkg::dbl_op_e op, input logic [31:0] pair, input logic [31:0] memory_operand,
                     input logic ext, input logic [31:0] exp, input logic [5:0] f);
    int i;
    ld = 1'h1;
    ld_val = memory_operand;
    @(negedge core_clk);
    ld = 1'h0;
    req = '{op, pair[31:16], pair[15:0], mem_q[31:16], mem_q[15:0], ext};
    start = 1'h1;
    @(negedge core_clk);
    start = 1'h0;
    for (i = 0; i < 40 && done !== 1'h1; i++) @(negedge core_clk);
    if (done !== 1'h1) begin
      error_cnt++;
      $display("wrong value done expected 1 seen %b", done);
      finish_test();
    end
    chk("pair", exp, {rsp.acc_a, rsp.acc_b});
    chk("flags", 32'(f), 32'({rsp.ovf & rsp.ovf_we, rsp.ext, rsp.mem_we, rsp.pc_ofs}));
    @(negedge core_clk);
  endtask : run
  // ==========================================================
  // Scenarios
  task automatic t_addsub;
    run(dbl_int_pkg::OP_ADD, 32'h7FFFFFFF, 32'h1, 1'h0, 32'h80000000, 6'h21);
    run(dbl_int_pkg::OP_ADD, 32'hFFFFFFFF, 32'h2, 1'h0, 32'h1, 6'h11);
    run(dbl_int_pkg::OP_SUB, 32'h0, 32'h1, 1'h0, 32'hFFFFFFFF, 6'h11);
    run(dbl_int_pkg::OP_SUB, 32'h80000000, 32'h1, 1'h1, 32'h7FFFFFFF, 6'h31);
    run(dbl_int_pkg::OP_RSUB, 32'h7, 32'h5, 1'h0, 32'hFFFFFFFE, 6'h11);
  endtask : t_addsub
  task automatic t_unary;
    run(dbl_int_pkg::OP_NEG, 32'h80000000, 32'h0, 1'h0, 32'h80000000, 6'h21);
    run(dbl_int_pkg::OP_NEG, 32'h0, 32'h0, 1'h0, 32'h0, 6'h11);
    run(dbl_int_pkg::OP_NEG, 32'h5, 32'h0, 1'h0, 32'hFFFFFFFB, 6'h01);
    run(dbl_int_pkg::OP_INC, 32'hFFFFFFFF, 32'h0, 1'h0, 32'h0, 6'h11);
    run(dbl_int_pkg::OP_DEC, 32'h80000000, 32'h0, 1'h0, 32'h7FFFFFFF, 6'h21);
    run(dbl_int_pkg::OP_DEC, 32'h0, 32'h0, 1'h0, 32'hFFFFFFFF, 6'h11);
  endtask : t_unary
  task automatic t_mem;
    run(dbl_int_pkg::OP_MINC, 32'h12345678, 32'hFFFFFFFF, 1'h0, 32'h12345678, 6'h0A);
    chk("memory", 32'h0, mem_q);
    run(dbl_int_pkg::OP_MDEC, 32'h1, 32'h0, 1'h0, 32'h1, 6'h09);
    chk("memory", 32'hFFFFFFFF, mem_q);
    run(dbl_int_pkg::OP_MDEC, 32'h1, 32'h1, 1'h0, 32'h1, 6'h0A);
  endtask : t_mem
  task automatic t_cmp;
    // Overflow is set first so that a compare which touched it would show
    run(dbl_int_pkg::OP_INC, 32'h7FFFFFFF, 32'h0, 1'h0, 32'h80000000, 6'h21);
    run(dbl_int_pkg::OP_CMP, 32'h9, 32'h9, 1'h0, 32'h9, 6'h02);
    run(dbl_int_pkg::OP_CMP, 32'hFFFFFFFF, 32'h1, 1'h0, 32'hFFFFFFFF, 6'h03);
    run(dbl_int_pkg::OP_CMP, 32'h1, 32'hFFFFFFFF, 1'h0, 32'h1, 6'h04);
    chk("overflow", 32'h1, 32'(ovf_q));
  endtask : t_cmp
  task automatic t_muldiv;
    run(dbl_int_pkg::OP_MUL, 32'h3, 32'hFFFFFFFC, 1'h0, 32'hFFFFFFF4, 6'h01);
    run(dbl_int_pkg::OP_MUL, 32'h10000, 32'h10000, 1'h0, 32'h7FFFFFFF, 6'h21);
    run(dbl_int_pkg::OP_DIV, 32'hFFFFFFF9, 32'h2, 1'h0, 32'hFFFFFFFD, 6'h01);
    chk("overflow", 32'h0, 32'(ovf_q));
    run(dbl_int_pkg::OP_DIV, 32'h5, 32'h0, 1'h0, 32'h7FFFFFFF, 6'h21);
    run(dbl_int_pkg::OP_RDIV, 32'h7, 32'h64, 1'h0, 32'hE, 6'h01);
    run(dbl_int_pkg::OP_RDIV, 32'hFFFFFFFF, 32'h80000000, 1'h0, 32'h7FFFFFFF, 6'h21);
    run(dbl_int_pkg::OP_RDIV, 32'h0, 32'h3, 1'h0, 32'h7FFFFFFF, 6'h21);
    chk("memory", 32'h3, mem_q);
  endtask : t_muldiv
  // ==========================================================
  // Main sequence
  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst_n = 1'h0;
    start = 1'h0;
    ld = 1'h0;
    ld_val = 32'h0;
    req = '0;
    repeat (10) @(negedge core_clk);
    chk("reset answer", 32'h0, 32'({done, busy, rsp.acc_a}));
    rst_n = 1'h1;
    t_addsub();
    t_unary();
    t_mem();
    t_cmp();
    t_muldiv();
    chk("resume address", 32'h21, 32'(pc_q));
    finish_test();
  end
endmodule : double_integer_arith_unit_bench
